/* File: core/dipc_chan.sv */
/*
 dipc_chan.sv: one contact input: synchroniser, debounce, polarity, edge events.
 assumes: pin high means contact closed; tick is a one-cycle millisecond enable.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dipc_consts.svh"
module dipc_chan import dipc_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	// contact and settings
	input wire logic pin,
	input wire logic enable,
	input wire logic [`DIPC_DB_W-1:0] db_ms,
	input wire dipc_chan_cfg_t cfg,
	// conditioned result
	output var dipc_chan_out_t out
);
	dipc_chan_st_t st_ff;
	dipc_chan_st_t nxt_st;
	always_comb begin
		logic pulse_edge;
		pulse_edge = 1'b0;
		nxt_st = st_ff;
		// sync1 is read only by sync2
		nxt_st.sync1 = pin;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.evt = 1'b0;
		if (!enable) begin
			nxt_st.cnt = '0;
			nxt_st.level = 1'b0;
		end else if (st_ff.sync2 == st_ff.level) begin
			// any return to the held level restarts the wait
			nxt_st.cnt = '0;
		end else if (tick) begin
			if ({1'b0, st_ff.cnt} + 8'h01 >= {1'b0, db_ms}) begin
				nxt_st.level = st_ff.sync2;
				nxt_st.cnt = '0;
				// normal: closing is the pulse; inverting: opening is
				pulse_edge = st_ff.sync2 ^ cfg.pulse_inv;
				if (cfg.kyz) nxt_st.evt = 1'b1;
				else nxt_st.evt = pulse_edge ^ cfg.trailing;
			end else begin
				nxt_st.cnt = st_ff.cnt + 7'h01;
			end
		end
		// inverting reports an open contact as closed
		// an unfitted input reports open whatever its polarity
		nxt_st.status = enable & (nxt_st.level ^ cfg.stat_inv);
		nxt_st.chg = (nxt_st.status != st_ff.status);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) st_ff <= '0;
		else st_ff <= nxt_st;
	end
	assign out = '{status: st_ff.status, level: st_ff.level, chg: st_ff.chg, evt: st_ff.evt};
endmodule
`default_nettype wire

/* File: core/dipc_tick.sv */
/*
 dipc_tick.sv: millisecond enable divider.
 assumes: runs on aclk; CYCLES fits the 17-bit counter.
*/
`timescale 1ns/100ps
`default_nettype none
module dipc_tick import dipc_pkg::*; #(
	parameter int unsigned CYCLES = 125000
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// one-cycle enable every CYCLES clocks
	output logic tick
);
	dipc_tick_st_t st_ff;
	dipc_tick_st_t nxt_st;
	// free-running count, wraps at the period
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = (st_ff.cnt == 17'(CYCLES - 1));
		nxt_st.cnt = nxt_st.tick ? 17'h00000 : st_ff.cnt + 17'h00001;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) st_ff <= '0;
		else st_ff <= nxt_st;
	end
	assign tick = st_ff.tick;
endmodule
`default_nettype wire

/* File: core/dipc_top.sv */
/*
 dipc_top.sv: digital input pulse conditioner with AXI4-Lite registers,
 interrupt logic and routing of each conditioned input.
 assumes: one 125 MHz aclk, synchronous active-low aresetn, contact pins
 asynchronous to aclk, one outstanding write and one outstanding read.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dipc_consts.svh"

// ==========================================================
// top level
module dipc_top import dipc_pkg::*; #(
	parameter int unsigned TICK_CYCLES = `DIPC_TICK_PERIOD_NS / `DIPC_CLK_PERIOD_NS,
	parameter int unsigned EXT_INPUTS = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// write data channel
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response channel
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address channel
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// read data channel
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// contact pins
	input wire logic demand_sync_input,
	input wire logic [`DIPC_NUM_IN-2:0] contact_in,
	// routed results
	output var dipc_vec_t sp_status,
	output var dipc_vec_t sp_change,
	output var dipc_vec_t counter_pulse,
	output var dipc_vec_t billing_pulse,
	output logic demand_sync_pulse,
	// interrupt
	output logic irq
);
	// ==========================================================
	// declarations
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int unsigned FITTED = `DIPC_STD_IN + EXT_INPUTS;

	dipc_top_st_t st_ff;
	dipc_top_st_t nxt_st;
	logic tick;
	dipc_vec_t pins;
	dipc_vec_t lvl;
	dipc_vec_t stat;
	dipc_vec_t chg;
	dipc_vec_t evt;
	dipc_chan_out_t chan_out [`DIPC_NUM_IN];

	// ==========================================================
	// register read decode, shared by reads and by byte-merged writes
	function automatic logic [32:0] rd_word(input dipc_top_st_t s, input logic [7:0] a);
		logic [32:0] r;
		r = 33'h000000000;
		case (a)
			`DIPC_OFF_CTRL: begin
				r[`DIPC_DB_W-1:0] = s.db;
				r[`DIPC_SYNC_EN_BIT] = s.sync_en;
			end
			`DIPC_OFF_STAT_INV: begin
				r[31:0] = 32'(s.stat_inv);
			end
			`DIPC_OFF_PULSE_INV: begin
				r[31:0] = 32'(s.pulse_inv);
			end
			`DIPC_OFF_KYZ: begin
				r[31:0] = 32'(s.kyz);
			end
			`DIPC_OFF_TRAIL: begin
				r[31:0] = 32'(s.trail);
			end
			`DIPC_OFF_ROUTE: begin
				r[31:0] = 32'(s.route);
			end
			`DIPC_OFF_LEVEL: begin
				r[31:0] = 32'(lvl);
			end
			`DIPC_OFF_STATUS: begin
				r[31:0] = 32'(s.sp_status);
			end
			`DIPC_OFF_IRQ_STAT: begin
				r[31:0] = s.irq_stat;
			end
			`DIPC_OFF_IRQ_MASK: begin
				r[31:0] = s.irq_mask;
			end
			`DIPC_OFF_INFO: begin
				r[31:0] = 32'(FITTED);
			end
			default: begin
				// unmapped word: error answer, data zero
				r[32] = 1'b1;
			end
		endcase
		return r;
	endfunction

	// ==========================================================
	// millisecond enable for the debounce counters
	dipc_tick #(
		.CYCLES(TICK_CYCLES)
	) i_dipc_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick)
	);

	// ==========================================================
	// one conditioner per input; unfitted inputs stay quiet
	assign pins = {contact_in, demand_sync_input};

	for (genvar i = 0; i < `DIPC_NUM_IN; i++) begin : g_chan
		dipc_chan i_dipc_chan (
			.aclk(aclk),
			.aresetn(aresetn),
			.tick(tick),
			.pin(pins[i]),
			.enable(1'(i < FITTED)),
			.db_ms(st_ff.db),
			.cfg(dipc_chan_cfg_t'{st_ff.stat_inv[i], st_ff.pulse_inv[i], st_ff.kyz[i],
				st_ff.trail[i]}),
			.out(chan_out[i])
		);
		assign lvl[i] = chan_out[i].level;
		assign stat[i] = chan_out[i].status;
		assign chg[i] = chan_out[i].chg;
		assign evt[i] = chan_out[i].evt;
	end

	// ==========================================================
	// next-state logic: bus slave, settings, interrupts, routing
	always_comb begin
		logic [32:0] old;
		logic [32:0] rd;
		logic [31:0] wr;
		logic [31:0] ev;
		logic clr;
		dipc_route_t rt;
		old = 33'h000000000;
		rd = 33'h000000000;
		wr = 32'h00000000;
		ev = 32'h00000000;
		clr = 1'b0;
		rt = DIPC_RT_NONE;
		nxt_st = st_ff;

		// capture write address and data in either order
		if (awvalid && !st_ff.aw_have) begin
			nxt_st.aw_have = 1'b1;
			nxt_st.awaddr = awaddr;
		end
		if (wvalid && !st_ff.w_have) begin
			nxt_st.w_have = 1'b1;
			nxt_st.wdata = wdata;
			nxt_st.wstrb = wstrb;
		end
		if (st_ff.bvalid && bready) begin
			nxt_st.bvalid = 1'b0;
		end

		// perform the write once both halves are held and no response is pending
		if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
			old = rd_word(st_ff, st_ff.awaddr);
			wr = dipc_merge(old[31:0], st_ff.wdata, st_ff.wstrb);
			nxt_st.aw_have = 1'b0;
			nxt_st.w_have = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = old[32] ? RESP_SLVERR : RESP_OKAY;
			case (st_ff.awaddr)
				`DIPC_OFF_CTRL: begin
					// out-of-range times are pulled to the nearest limit
					nxt_st.db = dipc_clamp_db(wr[`DIPC_DB_W-1:0]);
					nxt_st.sync_en = wr[`DIPC_SYNC_EN_BIT];
				end
				`DIPC_OFF_STAT_INV: begin
					nxt_st.stat_inv = wr[`DIPC_NUM_IN-1:0];
				end
				`DIPC_OFF_PULSE_INV: begin
					nxt_st.pulse_inv = wr[`DIPC_NUM_IN-1:0];
				end
				`DIPC_OFF_KYZ: begin
					nxt_st.kyz = wr[`DIPC_NUM_IN-1:0];
				end
				`DIPC_OFF_TRAIL: begin
					nxt_st.trail = wr[`DIPC_NUM_IN-1:0];
				end
				`DIPC_OFF_ROUTE: begin
					nxt_st.route = wr[2*`DIPC_NUM_IN-1:0];
				end
				`DIPC_OFF_IRQ_MASK: begin
					nxt_st.irq_mask = wr & `DIPC_IRQ_VALID;
				end
				default: begin
					// read-only and unmapped words change nothing
				end
			endcase
		end

		// read channel; a new read waits until the last answer is taken
		if (st_ff.rvalid && rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (arvalid && !st_ff.rvalid) begin
			rd = rd_word(st_ff, araddr);
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd[31:0];
			nxt_st.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
			clr = (araddr == `DIPC_OFF_IRQ_STAT);
		end

		// sticky events; a new event in the clearing cycle survives the clear
		ev = 32'(evt);
		ev = ev | (32'(chg) << `DIPC_IRQ_CHG_LSB);
		ev[`DIPC_IRQ_SYNC_BIT] = st_ff.sync_en & evt[0];
		nxt_st.irq_stat = (clr ? 32'h00000000 : st_ff.irq_stat) | ev;
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

		// routing: status levels always go to setpoints, edges where chosen
		nxt_st.sp_status = stat;
		nxt_st.sp_change = '0;
		nxt_st.counter_pulse = '0;
		nxt_st.billing_pulse = '0;
		for (int i = 0; i < `DIPC_NUM_IN; i++) begin
			rt = dipc_route_t'(st_ff.route[2*i +: 2]);
			case (rt)
				DIPC_RT_SETPOINT: begin
					nxt_st.sp_change[i] = chg[i];
				end
				DIPC_RT_COUNTER: begin
					nxt_st.counter_pulse[i] = evt[i];
				end
				DIPC_RT_BILLING: begin
					nxt_st.billing_pulse[i] = evt[i];
				end
				default: begin
					// input not routed
				end
			endcase
		end

		// external demand sync uses the first input's pulse events
		nxt_st.sync_pulse = st_ff.sync_en & evt[0];
	end

	// ==========================================================
	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.db <= `DIPC_DB_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// outputs; the ready signals are plain decodes of the held state
	assign awready = !st_ff.aw_have;
	assign wready = !st_ff.w_have;
	assign arready = !st_ff.rvalid;
	assign bvalid = st_ff.bvalid;
	assign bresp = st_ff.bresp;
	assign rvalid = st_ff.rvalid;
	assign rdata = st_ff.rdata;
	assign rresp = st_ff.rresp;
	assign sp_status = st_ff.sp_status;
	assign sp_change = st_ff.sp_change;
	assign counter_pulse = st_ff.counter_pulse;
	assign billing_pulse = st_ff.billing_pulse;
	assign demand_sync_pulse = st_ff.sync_pulse;
	assign irq = st_ff.irq;
endmodule
`default_nettype wire

/* File: inc/dipc_consts.svh */
/*
 dipc_consts.svh: register offsets, field positions, reset values and timing
 of the digital input pulse conditioner.
 assumes: included by bare name; holds definitions only.
*/
`ifndef DIPC_CONSTS_SVH
`define DIPC_CONSTS_SVH
// ==========================================================
// register byte offsets
`define DIPC_OFF_CTRL 8'h00
`define DIPC_OFF_STAT_INV 8'h04
`define DIPC_OFF_PULSE_INV 8'h08
`define DIPC_OFF_KYZ 8'h0c
`define DIPC_OFF_TRAIL 8'h10
`define DIPC_OFF_ROUTE 8'h14
`define DIPC_OFF_LEVEL 8'h18
`define DIPC_OFF_STATUS 8'h1c
`define DIPC_OFF_IRQ_STAT 8'h20
`define DIPC_OFF_IRQ_MASK 8'h24
`define DIPC_OFF_INFO 8'h28
// ==========================================================
// field layout
`define DIPC_NUM_IN 14
`define DIPC_STD_IN 2
`define DIPC_DB_W 7
`define DIPC_SYNC_EN_BIT 8
`define DIPC_IRQ_CHG_LSB 16
`define DIPC_IRQ_SYNC_BIT 31
`define DIPC_IRQ_VALID 32'hbfff3fff
// ==========================================================
// reset values and limits
`define DIPC_DB_RST 7'h0a
`define DIPC_DB_MIN 7'h01
`define DIPC_DB_MAX 7'h64
// ==========================================================
// timing
`define DIPC_CLK_PERIOD_NS 8
`define DIPC_TICK_PERIOD_NS 1000000
`endif

/* File: inc/dipc_pkg.sv */
/*
 dipc_pkg.sv: types and shared functions of the input conditioner.
 assumes: dipc_consts.svh is on the include path.
*/
`include "dipc_consts.svh"
package dipc_pkg;
	// ==========================================================
	// carriers
	typedef logic [`DIPC_NUM_IN-1:0] dipc_vec_t;
	typedef enum logic [1:0] {
		DIPC_RT_SETPOINT = 2'h0,
		DIPC_RT_COUNTER = 2'h1,
		DIPC_RT_BILLING = 2'h2,
		DIPC_RT_NONE = 2'h3
	} dipc_route_t;
	typedef struct packed {logic stat_inv; logic pulse_inv; logic kyz; logic trailing;} dipc_chan_cfg_t;
	typedef struct packed {logic status; logic level; logic chg; logic evt;} dipc_chan_out_t;
	// ==========================================================
	// module state
	typedef struct packed {logic [16:0] cnt; logic tick;} dipc_tick_st_t;
	typedef struct packed {
		logic sync1; logic sync2; logic level; logic [`DIPC_DB_W-1:0] cnt;
		logic status; logic chg; logic evt;
	} dipc_chan_st_t;
	typedef struct packed {
		logic aw_have; logic [7:0] awaddr; logic w_have; logic [31:0] wdata; logic [3:0] wstrb;
		logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
		logic [`DIPC_DB_W-1:0] db; logic sync_en;
		dipc_vec_t stat_inv; dipc_vec_t pulse_inv; dipc_vec_t kyz; dipc_vec_t trail;
		logic [2*`DIPC_NUM_IN-1:0] route; logic [31:0] irq_stat; logic [31:0] irq_mask;
		dipc_vec_t sp_status; dipc_vec_t sp_change; dipc_vec_t counter_pulse;
		dipc_vec_t billing_pulse; logic sync_pulse; logic irq;
	} dipc_top_st_t;
	// ==========================================================
	// helpers
	function automatic logic [`DIPC_DB_W-1:0] dipc_clamp_db(input logic [`DIPC_DB_W-1:0] v);
		if (v > `DIPC_DB_MAX) return `DIPC_DB_MAX;
		if (v < `DIPC_DB_MIN) return `DIPC_DB_MIN;
		return v;
	endfunction
	function automatic logic [31:0] dipc_merge(input logic [31:0] old, input logic [31:0] wr,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) r[8*b +: 8] = wr[8*b +: 8];
		end
		return r;
	endfunction
endpackage

/* File: tb/dipc_contacts.sv */
/*
 dipc_contacts.sv: dry contacts in front of the input conditioner.
 assumes: the bench sets wanted levels and bounce masks on aclk edges.
*/
`timescale 1ns/100ps
`default_nettype none
module dipc_contacts (
	// clock
	input wire logic aclk,
	// wanted levels and contacts that chatter
	input wire logic [13:0] want,
	input wire logic [13:0] bounce,
	// contact pins, high means closed
	output logic demand_sync_input,
	output logic [12:0] contact_in
);
	logic flip = 1'b0;
	// a chattering contact flips every clock, faster than any debounce;
	// pins settle on the first edge, well inside the reset span
	always @(posedge aclk) begin
		flip <= !flip;
		{contact_in, demand_sync_input} <= want ^ (bounce & {14{flip}});
	end
endmodule
`default_nettype wire

/* File: tb/dipc_top_checker.sv */
/*
 dipc_top_checker.sv: assertions on the ports of dipc_top.
 assumes: bound into dipc_top; one clock aclk, reset aresetn.
*/
`timescale 1ns/100ps
`default_nettype none
module dipc_top_checker import dipc_pkg::*; #(
	parameter int unsigned EXT_INPUTS = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// routed results
	input wire dipc_vec_t sp_status,
	input wire dipc_vec_t sp_change,
	input wire dipc_vec_t counter_pulse,
	input wire dipc_vec_t billing_pulse
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// register bus
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_ar_block: assert property (rvalid |-> !arready)
		else $error("read address taken while data pending");
	a_read_lat: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_write_lat: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
		else $error("write answer late");
	// ==========================================================
	// conditioned inputs
	a_route_excl: assert property ((counter_pulse & billing_pulse) == '0 &&
		(sp_change & (counter_pulse | billing_pulse)) == '0)
		else $error("event routed twice");
	a_unfit_quiet: assert property (((sp_status | sp_change | counter_pulse | billing_pulse)
		>> (2 + EXT_INPUTS)) == '0)
		else $error("unfitted input active");
	a_evt_single: assert property ((counter_pulse | billing_pulse) != '0 |=>
		((counter_pulse | billing_pulse) & $past(counter_pulse | billing_pulse)) == '0)
		else $error("event longer than one cycle");
	a_chg_status: assert property (sp_change != '0 |-> sp_status != $past(sp_status))
		else $error("change without status flip");
endmodule
bind dipc_top dipc_top_checker #(.EXT_INPUTS(EXT_INPUTS)) i_dipc_top_checker (.aclk, .aresetn,
	.awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata,
	.rvalid, .rready, .sp_status, .sp_change, .counter_pulse, .billing_pulse);
`default_nettype wire

/* File: tb/testbench.sv */
/*
 testbench.sv: register, debounce, edge, routing and sync scenarios.
 assumes: dipc_pkg, dipc_top, checker and contact model compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dipc_consts.svh"
module testbench import dipc_pkg::*;;
	localparam int TK = 10;
	localparam int EXT = 8;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, dsi, dsp, irq;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, r;
	logic [12:0] cin;
	logic [13:0] want = 14'h0, bounce = 14'h0;
	dipc_vec_t sps, spc, cp, bp;
	int n_mismatch = 0, tests_run = 0, cyc = 0, db = 10, t0, c, nd = 0;
	int nc[14] = '{default: 0}, nb[14] = '{default: 0}, ns[14] = '{default: 0};
	dipc_top #(.TICK_CYCLES(TK), .EXT_INPUTS(EXT)) i_dipc_top (.aclk, .aresetn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .demand_sync_input(dsi),
		.contact_in(cin), .sp_status(sps), .sp_change(spc), .counter_pulse(cp),
		.billing_pulse(bp), .demand_sync_pulse(dsp), .irq);
	dipc_contacts i_dipc_contacts (.aclk, .want, .bounce, .demand_sync_input(dsi),
		.contact_in(cin));
	always #4 aclk = ~aclk;
	// tally one-cycle events so no pulse is missed between checks
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		nd <= nd + (dsp === 1'b1);
		for (int i = 0; i < 14; i++) begin
			nc[i] <= nc[i] + (cp[i] === 1'b1);
			nb[i] <= nb[i] + (bp[i] === 1'b1);
			ns[i] <= ns[i] + (spc[i] === 1'b1);
		end
	end
	// ==========================================================
	// compares and bus tasks
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk_in(input string s, input int lo, input int hi, input int g);
		tests_run++;
		if (g < lo || g > hi) begin
			n_mismatch++;
			$display("mismatch %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask
	// ready is looked at on the falling edge, so it equals the value at the next rising edge;
	// bready and rready stay up between calls, so no call lowers and raises one in a step
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		logic ha, hw;
		ha = 1'b0;
		hw = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ha = ha | (awvalid & awready);
			hw = hw | (wvalid & wready);
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
		end while (!(ha && hw));
		do begin
			@(negedge aclk);
			ha = bvalid;
			if (ha) chk("bresp", e, bresp);
			@(posedge aclk);
		end while (!ha);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic h;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			h = arready;
			@(posedge aclk);
		end while (!h);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			h = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge aclk);
		end while (!h);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		rd(a, d, r);
		chk("rdata", e, d);
		chk("rresp", er, r);
	endtask
	// hold new contact levels for one debounce span plus the pipeline
	task automatic pins(input logic [13:0] v);
		want <= v;
		repeat (db * TK + 10) @(posedge aclk);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==========================================================
	// scenarios
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc(`DIPC_OFF_CTRL, 32'h0000000a, 2'h0);
		wr(`DIPC_OFF_CTRL, 32'h00000000, 2'h0);
		rdc(`DIPC_OFF_CTRL, 32'h00000001, 2'h0);
		wr(`DIPC_OFF_CTRL, 32'h0000007f, 2'h0);
		rdc(`DIPC_OFF_CTRL, 32'h00000064, 2'h0);
		wr(8'h30, 32'h00000001, 2'h2);
		rdc(8'h30, 32'h00000000, 2'h2);
		rdc(`DIPC_OFF_INFO, 2 + EXT, 2'h0);
		// only the second byte lane lands: sync enable set, debounce kept
		wstrb <= 4'h2;
		wr(`DIPC_OFF_CTRL, 32'h0000017f, 2'h0);
		rdc(`DIPC_OFF_CTRL, 32'h00000164, 2'h0);
		wstrb <= 4'hf;
		wr(`DIPC_OFF_CTRL, 32'h0000000a, 2'h0);
		wr(`DIPC_OFF_ROUTE, 32'h0fffff25, 2'h0);
		$display("test registers done");
		// chatter must never pass; a steady closing passes after the debounce span
		bounce <= 14'h0002;
		want <= 14'h0002;
		repeat (300) @(posedge aclk);
		chk("chatter events", 0, nc[1]);
		bounce <= 14'h0000;
		t0 = cyc;
		while (nc[1] == 0 && cyc - t0 < 2000) @(posedge aclk);
		chk_in("debounce cycles", (db - 1) * TK, db * TK + 8, cyc - t0);
		wr(`DIPC_OFF_CTRL, 32'h00000003, 2'h0);
		db = 3;
		want <= 14'h0004;
		t0 = cyc;
		while (nb[2] == 0 && cyc - t0 < 2000) @(posedge aclk);
		chk_in("short debounce", 2 * TK, 3 * TK + 8, cyc - t0);
		rdc(`DIPC_OFF_LEVEL, 32'h00000004, 2'h0);
		$display("test debounce done");
		// every polarity and edge choice of single-edge mode
		for (int k = 0; k < 4; k++) begin
			wr(`DIPC_OFF_PULSE_INV, {30'h0, k[1], 1'b0}, 2'h0);
			wr(`DIPC_OFF_TRAIL, {30'h0, k[0], 1'b0}, 2'h0);
			c = nc[1];
			pins(want | 14'h0002);
			chk("closing events", 1 ^ k[1] ^ k[0], nc[1] - c);
			c = nc[1];
			pins(want & 14'h3ffd);
			chk("opening events", k[1] ^ k[0], nc[1] - c);
		end
		wr(`DIPC_OFF_KYZ, 32'h00000002, 2'h0);
		c = nc[1];
		pins(want | 14'h0002);
		pins(want & 14'h3ffd);
		chk("transition events", 2, nc[1] - c);
		$display("test edges done");
		pins(want | 14'h2008);
		chk("status closed", 1, sps[3]);
		rdc(`DIPC_OFF_LEVEL, 32'h0000000c, 2'h0);
		wr(`DIPC_OFF_STAT_INV, 32'h00000008, 2'h0);
		// the new polarity needs two more clocks to reach the reported status
		repeat (2) @(posedge aclk);
		rdc(`DIPC_OFF_STATUS, 32'h00000004, 2'h0);
		chk("status inverted", 0, sps[3]);
		chk("status changes", 2, ns[3]);
		chk("routing", 1, nb[2] + nc[2] * 2 + nc[3] * 4 + ns[1] * 8 + nb[1] * 16);
		$display("test status and routing done");
		// demand sync through input 0, seen by its interrupt bit
		chk("irq masked", 0, irq);
		rd(`DIPC_OFF_IRQ_STAT, d, r);
		wr(`DIPC_OFF_IRQ_MASK, 32'hffffffff, 2'h0);
		rdc(`DIPC_OFF_IRQ_MASK, `DIPC_IRQ_VALID, 2'h0);
		wr(`DIPC_OFF_IRQ_MASK, 32'h80000001, 2'h0);
		wr(`DIPC_OFF_CTRL, 32'h00000103, 2'h0);
		pins(want | 14'h0001);
		chk("sync pulses", 1, nd);
		chk("irq raised", 1, irq);
		rd(`DIPC_OFF_IRQ_STAT, d, r);
		chk("irq status", 32'h80000001, d & 32'h80000001);
		rdc(`DIPC_OFF_IRQ_STAT, 32'h00000000, 2'h0);
		chk("irq cleared", 0, irq);
		wr(`DIPC_OFF_CTRL, 32'h00000003, 2'h0);
		pins(want & 14'h3ffe);
		pins(want | 14'h0001);
		chk("sync off", 1, nd);
		chk("input 0 events", 2, nc[0]);
		$display("test demand sync done");
		end_of_test();
	end
	// cut a hang short well past the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		end_of_test();
	end
endmodule
`default_nettype wire
